/* src/eth_frame_handler.sv */
/*
  Transmit and receive frame handling of a 10 Mbit Ethernet MAC.
  Assumes byte-wide streams: the host-side transmit stream comes from the
  packet memory, the medium side goes to and comes from the PHY byte path,
  and received bytes are written to the packet memory by the receive port.
*/
// The register offsets and strobed register access were chosen for this implementation.
// How it works
// R1: tx sends seven preamble bytes and a delimiter; rx strips them before storing.
// R2: rx stores padding and the four CRC bytes with the frame.
// R3: first destination byte bit zero set means multicast, else unicast.
// R4: all-ones destination is broadcast, also counted as multicast.
// R5: rx filters accept frames by unicast, multicast or broadcast type.
// R6: station address only feeds the unicast filter, never transmitted.
// R7: host writes destination and source addresses into every transmit frame.
// R8: type/length at most 05DCh is a length, larger is a type.
// R9: data up to 1500 bytes; huge frame enable lifts the length limit.
// R10: pad selection zero-pads transmit frames to at least 60 bytes.
// R11: without auto padding the host pads short frames itself.
// R12: undersize frames are sent unblocked when padding is off.
// R13: received frames under 18 bytes are rejected.
// R14: host discards received frames under 64 bytes itself.
// R15: CRC checked on every frame; bad ones dropped when CRC filter enabled.
// R16: CRC filter off stores bad frames; CRC state goes in status.
// R17: frame check is standard 32-bit CRC over destination through padding.
// R18: CRC appended on transmit when configured, else host supplies it.
// R19: standard frames span 64 to 1518 bytes without preamble and delimiter.
// R20: programmable maximum frame length limits received and sent frames.
`timescale 1ns/10ps
module eth_frame_handler (
  input  wire logic        sys_clk,      // system clock, 20 MHz
  input  wire logic        nrst,         // asynchronous reset, active low
  input  wire logic [3:0]  regAddr,      // register address
  input  wire logic [7:0]  regWrData,    // register write data
  input  wire logic        regWrite,     // register write strobe
  input  wire logic        regRead,      // register read strobe
  output logic      [7:0]  regRdData,    // read data, cycle after strobe
  input  wire logic        txStart,      // start one transmit frame
  input  wire logic [7:0]  txInData,     // frame byte from transmit buffer
  input  wire logic        txInValid,    // txInData holds a byte
  input  wire logic        txInLast,     // this is the final buffer byte
  output logic             txInReady,    // byte taken this cycle
  output logic [7:0]       phyTxData,    // byte to the medium
  output logic             phyTxValid,   // phyTxData valid
  input  wire logic        phyTxReady,   // medium accepts byte
  output logic             txBusy,       // frame in progress
  input  wire logic [7:0]  phyRxData,    // byte from the medium
  input  wire logic        phyRxValid,   // phyRxData valid
  input  wire logic        phyRxActive,  // carrier of a frame on the medium
  output logic [7:0]       rxOutData,    // byte to the receive buffer
  output logic             rxOutValid,   // rxOutData valid
  output logic             rxCommit,     // pulse: frame kept
  output logic             rxDiscard     // pulse: frame dropped
);
  import eth_frame_pkg::*;

  function automatic logic [31:0] crcByte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY_REV) : (r >> 1);
    end
    return r;
  endfunction

  // register file
  logic [7:0]  macControlThree;
  logic [7:0]  receiveFilterControl;
  logic [15:0] maxFrameLength;
  logic [7:0]  stationAddr [6];
  logic [7:0]  rxStatus;
  logic [15:0] rxCount;

  wire [2:0] padCrcConfig  = macControlThree[PAD_CRC_CONFIG_LSB +: 3];
  wire       hugeFrameEn   = macControlThree[BIT_HUGE_FRAME_EN];
  wire       crcFilterEn   = receiveFilterControl[BIT_FILT_CRC];
  // pad field: any nonzero code enables pad and CRC; the tx CRC bit adds CRC alone
  wire       txPadEn       = padCrcConfig != 3'b000;                     // see R10 R12
  wire       txCrcEn       = txPadEn | macControlThree[BIT_TX_CRC_EN];   // see R18
  wire       saIndexed     = regAddr >= OFS_STATION_ADDR0 && regAddr <= OFS_STATION_ADDR5;
  wire [2:0] saIndex       = 3'(regAddr - OFS_STATION_ADDR0);
  // register selects shared by the read mux and the write decode
  wire       selMac3       = regAddr == OFS_MAC_CONTROL_THREE;
  wire       selFilter     = regAddr == OFS_RX_FILTER_CONTROL;
  wire       selMaxLo      = regAddr == OFS_MAX_FRAME_LEN_LO;
  wire       selMaxHi      = regAddr == OFS_MAX_FRAME_LEN_HI;

  logic [7:0] next_rdData;
  always_comb begin
    next_rdData = 8'h00;
    unique case (1'b1)
      selMac3:                          next_rdData = macControlThree;
      selFilter:                        next_rdData = receiveFilterControl;
      selMaxLo:                         next_rdData = maxFrameLength[7:0];
      selMaxHi:                         next_rdData = maxFrameLength[15:8];
      saIndexed:                        next_rdData = stationAddr[saIndex];
      regAddr == OFS_RX_STATUS:         next_rdData = rxStatus;
      regAddr == OFS_RX_COUNT_LO:       next_rdData = rxCount[7:0];
      regAddr == OFS_RX_COUNT_HI:       next_rdData = rxCount[15:8];
      default:                          next_rdData = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      regRdData <= next_rdData;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      macControlThree      <= MAC3_RESET;
      receiveFilterControl <= RXFILT_RESET;
      maxFrameLength       <= MAX_LEN_RESET;                             // see R19 R20
      for (int i = 0; i < 6; i++) stationAddr[i] <= 8'h00;
    end else if (regWrite) begin
      if (selMac3) macControlThree <= regWrData;
      if (selFilter) receiveFilterControl <= regWrData;
      if (selMaxLo) maxFrameLength[7:0] <= regWrData;
      if (selMaxHi) maxFrameLength[15:8] <= regWrData;
      if (saIndexed) stationAddr[saIndex] <= regWrData;
    end
  end

  // ---------------- transmit ----------------
  // station address is never inserted: the host supplies both addresses
  tx_state_t   txState;                                                  // see R6 R7
  logic [15:0] txCount;
  logic [31:0] txCrc;
  logic [3:0]  txSub;

  wire txMove    = phyTxValid & phyTxReady;
  wire txTakeIn  = txState == TX_DATA & txInValid & (~phyTxValid | phyTxReady);
  wire txTooLong = ~hugeFrameEn & txCount >= maxFrameLength;            // see R9 R20
  wire [15:0] txCountInc = txCount + 16'h0001;

  // the one combinational output: a byte is taken in the cycle the medium frees its slot
  assign txInReady = txTakeIn;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      txState    <= TX_IDLE;
      txCount    <= 16'h0000;
      txCrc      <= 32'hFFFFFFFF;
      txSub      <= 4'h0;
      phyTxData  <= 8'h00;
      phyTxValid <= 1'b0;
      txBusy     <= 1'b0;
    end else begin
      if (txMove) phyTxValid <= 1'b0;
      unique case (txState)
        TX_IDLE: if (txStart) begin
          txState <= TX_PRE;
          txSub   <= 4'h0;
          txCount <= 16'h0000;
          txCrc   <= 32'hFFFFFFFF;
          txBusy  <= 1'b1;
        end
        TX_PRE: if (!phyTxValid || txMove) begin
          phyTxData  <= PREAMBLE_BYTE;                                   // see R1
          phyTxValid <= 1'b1;
          txSub      <= txSub + 4'h1;
          if (txSub == PREAMBLE_BYTES - 4'h1) txState <= TX_SFD;
        end
        TX_SFD: if (!phyTxValid || txMove) begin
          phyTxData  <= SFD_BYTE;                                        // see R1
          phyTxValid <= 1'b1;
          txState    <= TX_DATA;
        end
        TX_DATA: if (txTakeIn) begin
          // bytes past the maximum length are consumed but not sent
          phyTxData  <= txInData;
          phyTxValid <= ~txTooLong;                                      // see R20
          txCrc      <= crcByte(txCrc, txInData);                        // see R17
          txCount    <= txCountInc;
          if (txInLast) begin
            txSub <= 4'h0;
            if (txPadEn && txCountInc < MIN_PAD_LEN) txState <= TX_PAD;  // see R10
            else if (txCrcEn) txState <= TX_FCS;                         // see R18
            else begin
              txState <= TX_IDLE;                                        // see R12
              txBusy  <= 1'b0;
            end
          end
        end
        TX_PAD: if (!phyTxValid || txMove) begin
          phyTxData  <= 8'h00;                                           // see R10
          phyTxValid <= 1'b1;
          txCrc      <= crcByte(txCrc, 8'h00);
          txCount    <= txCountInc;
          if (txCountInc >= MIN_PAD_LEN) txState <= TX_FCS;
        end
        // check sequence goes out low byte first, inverted
        TX_FCS: if (!phyTxValid || txMove) begin
          phyTxData  <= ~txCrc[8*txSub[1:0] +: 8];                       // see R17 R18
          phyTxValid <= 1'b1;
          txSub      <= txSub + 4'h1;
          if (txSub == 4'h3) begin
            txState <= TX_IDLE;
            txBusy  <= 1'b0;
          end
        end
        default: txState <= TX_IDLE;
      endcase
    end
  end

  // ---------------- receive ----------------
  logic        rxInFrame;   // delimiter seen
  logic [15:0] rxLen;
  logic [31:0] rxCrc;
  logic        rxBcast;
  logic        rxMcast;
  logic        rxUcastHit;
  logic [7:0]  rxTypeHi;
  logic        rxLenField;
  logic        rxActiveD;

  wire rxByte = phyRxValid & phyRxActive;
  wire [15:0] rxLenInc = rxLen + 16'h0001;
  wire [2:0]  rxIdx    = 3'(rxLen);
  wire inDest = rxLen < 16'(DEST_BYTES);
  wire rxEnd  = rxActiveD & ~phyRxActive;
  wire crcOk  = rxCrc == CRC_RESIDUE;                                    // see R15 R17
  wire tooLong  = ~hugeFrameEn & rxLen > maxFrameLength;                 // see R9 R20
  wire isUcast  = ~rxMcast;                                              // see R3
  wire filtUc   = receiveFilterControl[BIT_FILT_UNICAST];
  wire filtMc   = receiveFilterControl[BIT_FILT_MULTICAST];
  wire filtBc   = receiveFilterControl[BIT_FILT_BROADCAST];
  wire noFilter = ~filtUc & ~filtMc & ~filtBc;
  wire passAddr = noFilter | (filtUc & isUcast & rxUcastHit)             // see R5 R6
                | (filtMc & rxMcast) | (filtBc & rxBcast);               // see R4 R5
  // verdict at carrier drop; the buffer side rolls back streamed bytes on discard
  wire keep = rxLen >= MIN_RX_LEN & ~tooLong                             // see R13
            & (crcOk | ~crcFilterEn) & passAddr;                         // see R15 R16

  // status word of the frame that is ending
  logic [7:0] next_rxStatus;
  always_comb begin
    next_rxStatus                   = 8'h00;
    next_rxStatus[BIT_ST_CRC_OK]    = crcOk;                             // see R16
    next_rxStatus[BIT_ST_MULTICAST] = rxMcast;                           // see R3
    next_rxStatus[BIT_ST_BROADCAST] = rxBcast & rxMcast;                 // see R4
    next_rxStatus[BIT_ST_UNICAST]   = isUcast;
    next_rxStatus[BIT_ST_TOO_LONG]  = tooLong;
    next_rxStatus[BIT_ST_LEN_FIELD] = rxLenField;                        // see R8
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rxInFrame  <= 1'b0;
      rxLen      <= 16'h0000;
      rxCrc      <= 32'hFFFFFFFF;
      rxBcast    <= 1'b0;
      rxMcast    <= 1'b0;
      rxUcastHit <= 1'b0;
      rxTypeHi   <= 8'h00;
      rxLenField <= 1'b0;
      rxActiveD  <= 1'b0;
      rxOutData  <= 8'h00;
      rxOutValid <= 1'b0;
      rxCommit   <= 1'b0;
      rxDiscard  <= 1'b0;
      rxStatus   <= 8'h00;
      rxCount    <= 16'h0000;
    end else begin
      rxActiveD  <= phyRxActive;
      rxOutValid <= 1'b0;
      rxCommit   <= 1'b0;
      rxDiscard  <= 1'b0;
      if (!rxInFrame) begin
        // preamble bytes are dropped until the delimiter
        if (rxByte && phyRxData == SFD_BYTE) begin                       // see R1
          rxInFrame  <= 1'b1;
          rxLen      <= 16'h0000;
          rxCrc      <= 32'hFFFFFFFF;
          rxBcast    <= 1'b1;
          rxUcastHit <= 1'b1;
        end
      end else if (rxByte) begin
        // every byte including pad and CRC goes to the buffer
        rxOutData  <= phyRxData;                                         // see R2
        rxOutValid <= 1'b1;
        rxCrc      <= crcByte(rxCrc, phyRxData);
        rxLen      <= rxLenInc;
        if (inDest) begin
          if (rxLen == 16'h0000) rxMcast <= phyRxData[0];                // see R3
          if (phyRxData != BCAST_BYTE) rxBcast <= 1'b0;                  // see R4
          if (phyRxData != stationAddr[rxIdx]) rxUcastHit <= 1'b0;
        end
        if (rxLen == 16'h000C) rxTypeHi <= phyRxData;
        if (rxLen == 16'h000D) rxLenField <= {rxTypeHi, phyRxData} <= TYPE_LEN_LIMIT; // see R8
      end
      if (rxEnd && rxInFrame) begin
        rxInFrame <= 1'b0;
        rxCommit  <= keep;
        rxDiscard <= ~keep;
        rxCount   <= rxLen;
        rxStatus  <= next_rxStatus;                                      // see R16
      end
    end
  end
endmodule

/* src/eth_frame_pkg.sv */
/*
  Constants shared by the Ethernet frame handler: register offsets, field
  positions, reset values, frame length limits and CRC constants.
  Assumes a byte-wide register port and byte-wide medium streams.
*/
package eth_frame_pkg;
  localparam logic [3:0] OFS_MAC_CONTROL_THREE = 4'h0;
  localparam logic [3:0] OFS_RX_FILTER_CONTROL = 4'h1;
  localparam logic [3:0] OFS_MAX_FRAME_LEN_LO  = 4'h2;
  localparam logic [3:0] OFS_MAX_FRAME_LEN_HI  = 4'h3;
  localparam logic [3:0] OFS_STATION_ADDR0     = 4'h4;
  localparam logic [3:0] OFS_STATION_ADDR5     = 4'h9;
  localparam logic [3:0] OFS_RX_STATUS         = 4'hA;
  localparam logic [3:0] OFS_RX_COUNT_LO       = 4'hB;
  localparam logic [3:0] OFS_RX_COUNT_HI       = 4'hC;

  // mac_control_three fields
  localparam int PAD_CRC_CONFIG_LSB = 5;
  localparam int BIT_HUGE_FRAME_EN  = 2;
  localparam int BIT_TX_CRC_EN      = 4;
  // receive_filter_control fields
  localparam int BIT_FILT_UNICAST   = 7;
  localparam int BIT_FILT_CRC       = 5;
  localparam int BIT_FILT_MULTICAST = 1;
  localparam int BIT_FILT_BROADCAST = 0;
  // receive status fields
  localparam int BIT_ST_CRC_OK    = 0;
  localparam int BIT_ST_MULTICAST = 1;
  localparam int BIT_ST_BROADCAST = 2;
  localparam int BIT_ST_UNICAST   = 3;
  localparam int BIT_ST_TOO_LONG  = 4;
  localparam int BIT_ST_LEN_FIELD = 5;

  localparam logic [7:0]  MAC3_RESET     = 8'h00;
  localparam logic [7:0]  RXFILT_RESET   = 8'hA1;
  localparam logic [15:0] MAX_LEN_RESET  = 16'h05EE;  // 1518
  localparam logic [15:0] MIN_RX_LEN     = 16'h0012;  // 18 bytes
  localparam logic [15:0] MIN_PAD_LEN    = 16'h003C;  // 60 bytes
  localparam logic [15:0] TYPE_LEN_LIMIT = 16'h05DC;  // 1500
  localparam logic [3:0]  PREAMBLE_BYTES = 4'h7;
  localparam logic [7:0]  PREAMBLE_BYTE  = 8'h55;
  localparam logic [7:0]  SFD_BYTE       = 8'hD5;
  localparam logic [7:0]  BCAST_BYTE     = 8'hFF;
  localparam logic [2:0]  DEST_BYTES     = 3'h6;
  localparam logic [31:0] CRC_POLY_REV   = 32'hEDB88320;
  localparam logic [31:0] CRC_RESIDUE    = 32'hDEBB20E3;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_PRE  = 3'b001,
    TX_SFD  = 3'b010,
    TX_DATA = 3'b011,
    TX_PAD  = 3'b100,
    TX_FCS  = 3'b101
  } tx_state_t;
endpackage

/* dv/eth_frame_handler_props.sv */
/*
  Port timing checker for the frame handler.
  Assumes it is bound to eth_frame_handler and sees only its ports.
*/
`timescale 1ns/10ps
module eth_frame_handler_props (
  input wire logic       sys_clk,     // clock
  input wire logic       nrst,        // reset, active low
  input wire logic [3:0] regAddr,     // register address
  input wire logic       regRead,     // read strobe
  input wire logic [7:0] regRdData,   // read data
  input wire logic       txStart,     // frame start
  input wire logic       txBusy,      // frame in progress
  input wire logic [7:0] phyTxData,   // medium byte out
  input wire logic       phyTxValid,  // medium byte valid
  input wire logic       phyTxReady,  // medium accepts
  input wire logic       phyRxValid,  // medium byte in valid
  input wire logic       phyRxActive, // carrier
  input wire logic       rxOutValid,  // stored byte valid
  input wire logic       rxCommit,    // frame kept
  input wire logic       rxDiscard    // frame dropped
);
  import eth_frame_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_start;
    txStart && !txBusy && !phyTxValid |=> txBusy ##1 (phyTxValid && phyTxData == PREAMBLE_BYTE);
  endproperty
  a_start: assert property (p_start) else $error("preamble start late");
  property p_tx_hold; phyTxValid && !phyTxReady |=> phyTxValid && $stable(phyTxData); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte dropped");
  property p_idle; !txBusy && !phyTxValid && !txStart |=> !phyTxValid; endproperty
  a_idle: assert property (p_idle) else $error("tx byte while idle");
  property p_excl; rxCommit |-> !rxDiscard; endproperty
  a_excl: assert property (p_excl) else $error("commit and discard");
  property p_rx_end; rxCommit || rxDiscard |-> !$past(phyRxActive); endproperty
  a_rx_end: assert property (p_rx_end) else $error("verdict in frame");
  property p_rx_out; rxOutValid |-> $past(phyRxValid && phyRxActive); endproperty
  a_rx_out: assert property (p_rx_out) else $error("stored byte without input");
  property p_unmapped; regRead && regAddr > 4'hC |=> regRdData == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rd_hold; !regRead |=> $stable(regRdData); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule
bind eth_frame_handler eth_frame_handler_props i_props (.sys_clk(sys_clk), .nrst(nrst),
  .regAddr(regAddr), .regRead(regRead), .regRdData(regRdData), .txStart(txStart),
  .txBusy(txBusy), .phyTxData(phyTxData), .phyTxValid(phyTxValid), .phyTxReady(phyTxReady),
  .phyRxValid(phyRxValid), .phyRxActive(phyRxActive), .rxOutValid(rxOutValid),
  .rxCommit(rxCommit), .rxDiscard(rxDiscard));

/* dv/eth_medium_model.sv */
/*
  Medium model: takes transmitted bytes with stalls, sends framed receive bytes.
  Assumes send is called right after a rising clock edge.
*/
`timescale 1ns/10ps
module eth_medium_model (
  input wire logic       sys_clk,     // clock
  input wire logic [7:0] phyTxData,   // byte from the device
  input wire logic       phyTxValid,  // byte valid
  output logic           phyTxReady,  // byte accepted
  output logic     [7:0] phyRxData,   // byte to the device
  output logic           phyRxValid,  // byte valid
  output logic           phyRxActive  // carrier
);
  logic [7:0] txSeen[$];
  logic [1:0] stallCnt = 2'h0;
  logic       sending = 1'b0;
  initial begin
    phyTxReady = 1'b0;
    phyRxData = 8'h00;
    phyRxValid = 1'b0;
    phyRxActive = 1'b0;
  end
  always @(posedge sys_clk) begin
    stallCnt <= stallCnt + 2'h1;
    phyTxReady <= (stallCnt != 2'h0);
    if (phyTxValid && phyTxReady) txSeen.push_back(phyTxData);
    // idle line changes every cycle
    if (!sending) phyRxData <= ~phyRxData;
  end
  task automatic send(input logic [7:0] q[$]);
    sending = 1'b1;
    phyRxActive <= 1'b1;
    for (int i = 0; i < q.size() + 8; i++) begin
      phyRxData <= (i < 7) ? 8'h55 : (i == 7) ? 8'hD5 : q[i-8];
      phyRxValid <= 1'b1;
      @(posedge sys_clk);
    end
    phyRxValid <= 1'b0;
    phyRxActive <= 1'b0;
    @(posedge sys_clk);
    sending = 1'b0;
  endtask
endmodule

/* dv/eth_frame_handler_test.sv */
/*
  Self-checking bench of the frame handler with a reference model.
  Assumes the medium model and the bound checker are compiled alongside.
*/
`timescale 1ns/10ps
module eth_frame_handler_test;
  import eth_frame_pkg::*;
  logic       sys_clk = 1'b0, nrst = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic       txStart = 1'b0, txInValid = 1'b0, txInLast = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00, txInData = 8'h00;
  logic [7:0] regRdData, phyTxData, phyRxData, rxOutData;
  logic       txInReady, phyTxValid, phyTxReady, txBusy, phyRxValid, phyRxActive;
  logic       rxOutValid, rxCommit, rxDiscard;
  int         error_cnt = 0, comparisons = 0, cycles = 0;
  logic [31:0] seed = 32'h521bc50e;
  logic [7:0] rxq[$], fr[$], dq[$];
  eth_frame_handler i_dut (.sys_clk(sys_clk), .nrst(nrst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .txStart(txStart), .txInData(txInData), .txInValid(txInValid), .txInLast(txInLast),
    .txInReady(txInReady), .phyTxData(phyTxData), .phyTxValid(phyTxValid),
    .phyTxReady(phyTxReady), .txBusy(txBusy), .phyRxData(phyRxData), .phyRxValid(phyRxValid),
    .phyRxActive(phyRxActive), .rxOutData(rxOutData), .rxOutValid(rxOutValid),
    .rxCommit(rxCommit), .rxDiscard(rxDiscard));
  eth_medium_model i_med (.sys_clk(sys_clk), .phyTxData(phyTxData), .phyTxValid(phyTxValid),
    .phyTxReady(phyTxReady), .phyRxData(phyRxData), .phyRxValid(phyRxValid),
    .phyRxActive(phyRxActive));
  always #25 sys_clk = ~sys_clk;
  task automatic wrap_up();
    if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (rxOutValid) rxq.push_back(rxOutData);
    if (cycles == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic void addfcs(ref logic [7:0] q[$]);
    logic [31:0] c = 32'hFFFFFFFF;
    foreach (q[i]) begin
      c ^= {24'h0, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY_REV : c >> 1;
    end
    for (int k = 0; k < 4; k++) q.push_back(~c[8*k +: 8]);
  endfunction
  task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdc(string nm, logic [3:0] a, logic [7:0] e);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    @(posedge sys_clk);
    chk8(nm, e, regRdData);
  endtask
  // destination, random source, type/length, random payload, good check sequence, then cut to n bytes
  task automatic build(logic [7:0] d0, int n, logic [15:0] tl);
    fr = {};
    for (int i = 0; i < 6; i++) fr.push_back(d0 == 8'hFF ? 8'hFF : i == 0 ? d0 : 8'(i + 1));
    repeat (6) fr.push_back(rnd());
    fr.push_back(tl[15:8]);
    fr.push_back(tl[7:0]);
    while (fr.size() < n - 4) fr.push_back(rnd());
    addfcs(fr);
    while (fr.size() > n) void'(fr.pop_back());
  endtask
  task automatic tx_case(logic [7:0] c3, int n, bit hostCrc);
    wr(OFS_MAC_CONTROL_THREE, c3);
    build(8'h10, hostCrc ? n : n + 4, 16'h0800);
    if (!hostCrc) repeat (4) void'(fr.pop_back());
    dq = fr;
    if (c3[7:5] != 3'h0) while (dq.size() < 60) dq.push_back(8'h00);
    if (c3[7:4] != 4'h0) addfcs(dq);
    i_med.txSeen = {};
    txStart <= 1'b1;
    @(posedge sys_clk);
    txStart <= 1'b0;
    foreach (fr[i]) begin
      txInData <= fr[i];
      txInValid <= 1'b1;
      txInLast <= (i == fr.size() - 1);
      do @(posedge sys_clk); while (txInReady !== 1'b1);
    end
    txInValid <= 1'b0;
    do @(posedge sys_clk); while (txBusy !== 1'b0 || phyTxValid !== 1'b0);
    chk8("tx length", 8'(dq.size() + 8), 8'(i_med.txSeen.size()));
    for (int i = 0; i < dq.size() + 8; i++)
      chk8("tx byte", i < 7 ? 8'h55 : i == 7 ? 8'hD5 : dq[i-8], i_med.txSeen[i]);
  endtask
  task automatic rx_case(logic [7:0] d0, int n, bit bad, logic [7:0] f, logic [7:0] c3,
                         logic [15:0] ml, logic [15:0] tl);
    logic mc, bc, ok;
    wr(OFS_RX_FILTER_CONTROL, f);
    wr(OFS_MAC_CONTROL_THREE, c3);
    wr(OFS_MAX_FRAME_LEN_LO, ml[7:0]);
    wr(OFS_MAX_FRAME_LEN_HI, ml[15:8]);
    build(d0, n, tl);
    if (bad) fr[$] ^= 8'h01;
    mc = fr[0][0];
    bc = (d0 == 8'hFF);
    ok = n >= 18 && (n <= ml || c3[2]) && (!bad || !f[5]) && ((f & 8'h83) == 8'h00
         || (f[7] && d0 == 8'h00) || (f[1] && mc) || (f[0] && bc));
    rxq = {};
    i_med.send(fr);
    for (int k = 0; k < 10 && rxCommit !== 1'b1 && rxDiscard !== 1'b1; k++) @(posedge sys_clk);
    chk8("commit", {7'h00, ok}, {7'h00, rxCommit});
    chk8("discard", {7'h00, !ok}, {7'h00, rxDiscard});
    if (ok) begin
      chk8("stored length", 8'(n), 8'(rxq.size()));
      foreach (fr[i]) chk8("stored byte", fr[i], rxq[i]);
      rdc("status", OFS_RX_STATUS, {2'b00, tl <= TYPE_LEN_LIMIT, n > ml && !c3[2],
          !mc, bc, mc, !bad});
      rdc("count", OFS_RX_COUNT_LO, 8'(n));
      rdc("count high", OFS_RX_COUNT_HI, 8'h00);
    end
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    for (int a = 0; a < 16; a++)
      rdc("reset", 4'(a), a == 1 ? RXFILT_RESET : a == 2 ? MAX_LEN_RESET[7:0] :
          a == 3 ? MAX_LEN_RESET[15:8] : 8'h00);
    for (int a = 4; a < 10; a++) wr(4'(a), a == 4 ? 8'h00 : 8'(a - 3));
    tx_case(8'h20, 20, 1'b0);
    tx_case(8'h00, 14, 1'b0);
    tx_case(8'h10, 60, 1'b0);
    tx_case(8'h00, 64, 1'b1);
    tx_case(8'hA0, 30, 1'b0);
    rx_case(8'hFF, 64, 1'b0, 8'hA1, 8'h00, 16'd1518, 16'h0800);
    rx_case(8'h01, 64, 1'b0, 8'hA1, 8'h00, 16'd1518, 16'h0800);
    rx_case(8'h01, 64, 1'b0, 8'hA3, 8'h00, 16'd1518, 16'h002E);
    rx_case(8'h00, 64, 1'b0, 8'hA1, 8'h00, 16'd1518, 16'h002E);
    rx_case(8'h02, 64, 1'b0, 8'hA1, 8'h00, 16'd1518, 16'h0800);
    rx_case(8'h02, 64, 1'b0, 8'h00, 8'h00, 16'd1518, 16'h0800);
    rx_case(8'h00, 64, 1'b1, 8'hA1, 8'h00, 16'd1518, 16'h0800);
    rx_case(8'h00, 64, 1'b1, 8'h80, 8'h00, 16'd1518, 16'h05DD);
    rx_case(8'hFF, 17, 1'b0, 8'hA1, 8'h00, 16'd1518, 16'h0800);
    rx_case(8'hFF, 18, 1'b0, 8'h01, 8'h00, 16'd1518, 16'h05DC);
    rx_case(8'hFF, 101, 1'b0, 8'hA1, 8'h00, 16'd100, 16'h0800);
    rx_case(8'hFF, 101, 1'b0, 8'hA1, 8'h04, 16'd100, 16'h0800);
    wrap_up();
  end
endmodule
